// ==== instrument_status_reporting.v ====
// Status reporting registers of the meter_unit: questionable, standard
// event, status byte, power-on clear, error queue and device clear.
// Assumes commands arrive in order on the command port, one per cycle.
// Operation
// - Power-up clears standard event enable only when power-on clear is 1.
// - Range overloads set questionable bits 0, 1 and 9.
// - Limit test sets questionable bit 11 below low, 12 above high.
// - Questionable summary is OR of event AND enable.
// - Clear-status and event query both clear questionable event register.
// - Questionable enable cleared at power-up, preset, or write of zero.
// - Error queue holds 20 entries first-in first-out; query pops oldest.
// - Register queries return binary-weighted value of bits set.
// - Clear-status zeroes status byte summary and events, keeps enables.
// - Standard event enable loads mask; selected bits drive summary bit.
// - Operation-complete command sets event bit 0 after prior commands finish.
// - Operation-complete query answers 1 after prior commands complete.
// - Power-on clear setting is non-volatile, queryable, clears both masks.
// - Status byte query equals serial poll value, does not clear bit 6.
// - Device clear aborts measurement, idles trigger, empties buffers.
// - Device clear leaves status, error queue and settings unchanged.
// - Serial Ctrl-C character acts exactly like a bus device clear.
// - After device clear, data-terminal-ready output goes true.
// - Standard event layout bits 0,2,3,4,5,7; bits 1 and 6 read zero.
// - Serial poll clears only request service bit of status byte.
`timescale 1ns/100ps
`include "status_consts.vh"

module instrument_status_reporting (
	// Clock, reset and freeze
	input wire core_clk,
	input wire reset,
	input wire clk_en,
	// Power-up pulse and stored power-on clear setting
	input wire power_up,
	input wire psc_nv_in,
	output reg psc_nv_write_q,
	output reg psc_nv_value_q,
	// Command port
	input wire cmd_valid,
	input wire [3:0] cmd_code,
	input wire [15:0] cmd_data,
	input wire exec_busy,
	output wire cmd_ready,
	// Query response
	output reg resp_valid_q,
	output reg [15:0] resp_data_q,
	// Measurement events
	input wire ovld_volt,
	input wire ovld_curr,
	input wire ovld_ohms,
	input wire lim_low_fail,
	input wire lim_high_fail,
	input wire std_query_err,
	input wire std_dev_err,
	input wire std_exec_err,
	input wire std_cmd_err,
	input wire msg_avail,
	// Error queue
	input wire err_push,
	input wire [15:0] err_code,
	input wire err_pop,
	output wire [15:0] err_pop_code,
	output wire err_empty,
	// Serial poll and service request
	input wire serial_poll,
	output reg [7:0] poll_byte_q,
	output wire srq,
	// Device clear sources and actions
	input wire bus_dev_clear,
	input wire serial_rx_valid,
	input wire [7:0] serial_rx_char,
	output reg meas_abort_q,
	output reg trig_idle_q,
	output reg buf_flush_q,
	output reg dtr_q
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam ST_READY = 2'h0;
	localparam ST_WAIT = 2'h1;

	// Operation-complete sequencer
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg pending_opc_q;
	reg pending_opcq_q;

	// Event registers and their enable masks
	reg [15:0] ques_event_q;
	reg [15:0] ques_enable_q;
	reg [7:0] std_event_q;
	reg [7:0] std_enable_q;
	reg [7:0] sre_q;

	// Request service, power-on clear and power-up delay
	reg rqs_q;
	reg svc_prev_q;
	reg psc_q;
	reg pu_seen_q;

	// Summaries, status byte and command decode helpers
	wire ques_sum;
	wire std_sum;
	wire svc_sum;
	wire [7:0] stb_now;
	wire dev_clear;
	wire take;
	wire is_cls;
	wire [15:0] ques_set;
	wire [7:0] std_set;

	// ----------------------------------------
	// Summaries and status byte
	// ----------------------------------------
	assign ques_sum = |(ques_event_q & ques_enable_q);
	assign std_sum = |(std_event_q & std_enable_q);
	assign srq = rqs_q;

	// Status byte: bit 6 request, 5 standard, 4 message, 3 questionable
	assign stb_now = {1'b0, rqs_q, std_sum, msg_avail, ques_sum, 3'h0};

	// Enabled status byte bits, with the request service bit left out
	assign svc_sum = |(stb_now & sre_q & 8'hBF);

	// Ctrl-C is merged into the same clear path as the bus message
	assign dev_clear = bus_dev_clear || (serial_rx_valid && serial_rx_char == `CTRL_C_CHAR);

	// Commands are taken only while no synchronising wait is open
	// A command that meets a device clear is dropped, as the clear empties input
	assign cmd_ready = (state_q == ST_READY);
	assign take = cmd_valid && cmd_ready && !dev_clear;
	assign is_cls = take && cmd_code == `CMD_CLS;

	// Incoming event sources by bit
	assign ques_set = {3'h0, lim_high_fail, lim_low_fail, 1'b0, ovld_ohms, 7'h00, ovld_curr, ovld_volt};
	assign std_set = {1'b0, 1'b0, std_cmd_err, std_exec_err, std_dev_err, std_query_err, 1'b0,
		pending_opc_q && state_q == ST_WAIT && !exec_busy};

	// ----------------------------------------
	// Operation-complete wait sequencer
	// ----------------------------------------
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_READY: begin
				if (take && (cmd_code == `CMD_OPC || cmd_code == `CMD_OPC_QRY)) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// A device clear also closes an open wait
				if (!exec_busy || dev_clear) begin
					state_d = ST_READY;
				end
			end
			default: begin
				state_d = ST_READY;
			end
		endcase
	end

	// Sequencer register and pending flags
	// Each flag remembers which completion command opened the wait
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_READY;
			pending_opc_q <= 1'b0;
			pending_opcq_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			if (take && cmd_code == `CMD_OPC) begin
				pending_opc_q <= 1'b1;
			end else if (state_d == ST_READY) begin
				pending_opc_q <= 1'b0;
			end
			if (take && cmd_code == `CMD_OPC_QRY) begin
				pending_opcq_q <= 1'b1;
			end else if (state_d == ST_READY) begin
				pending_opcq_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Event registers: set wins over clear
	// ----------------------------------------
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ques_event_q <= 16'h0000;
			std_event_q <= 8'h00;
			pu_seen_q <= 1'b0;
		end else if (clk_en) begin
			// Power-on bit lands one cycle after the power-up pulse
			pu_seen_q <= power_up;
			// Read or clear restarts from this cycle's sources, so a set wins
			if (is_cls || (take && cmd_code == `CMD_QEV_QRY)) begin
				ques_event_q <= ques_set & `QUES_USED_MASK;
			end else begin
				ques_event_q <= (ques_event_q | ques_set) & `QUES_USED_MASK;
			end
			if (is_cls || (take && cmd_code == `CMD_ESR_QRY)) begin
				std_event_q <= (std_set | {pu_seen_q, 7'h00}) & `SEV_USED_MASK;
			end else begin
				std_event_q <= (std_event_q | std_set | {pu_seen_q, 7'h00}) & `SEV_USED_MASK;
			end
		end
	end

	// ----------------------------------------
	// Enable masks and power-on clear setting
	// ----------------------------------------
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ques_enable_q <= `QEN_RESET;
			std_enable_q <= `MASK8_RESET;
			sre_q <= `MASK8_RESET;
			psc_q <= 1'b1;
			psc_nv_write_q <= 1'b0;
			psc_nv_value_q <= 1'b0;
		end else if (clk_en) begin
			psc_nv_write_q <= 1'b0;
			// Power-up outranks any command taken in the same cycle
			if (power_up) begin
				psc_q <= psc_nv_in;
				ques_enable_q <= `QEN_RESET;
				if (psc_nv_in) begin
					std_enable_q <= `MASK8_RESET;
					sre_q <= `MASK8_RESET;
				end
			end else if (take) begin
				// Questionable mask writes drop bits the layout does not hold, service request writes drop bit 6; event enable keeps all 8
				if (cmd_code == `CMD_QEN_SET) begin
					ques_enable_q <= cmd_data & `QUES_USED_MASK;
				end else if (cmd_code == `CMD_PRESET) begin
					ques_enable_q <= `QEN_RESET;
				end else if (cmd_code == `CMD_ESE_SET) begin
					std_enable_q <= cmd_data[7:0];
				end else if (cmd_code == `CMD_SRE_SET) begin
					sre_q <= {cmd_data[7], 1'b0, cmd_data[5:0]};
				end else if (cmd_code == `CMD_PSC_SET) begin
					psc_q <= cmd_data[0];
					psc_nv_write_q <= 1'b1;
					psc_nv_value_q <= cmd_data[0];
				end
			end
		end
	end

	// ----------------------------------------
	// Request service and serial poll
	// ----------------------------------------
	// A new request needs a rising summary, so a standing condition does not
	// undo a poll at once; a set in the poll cycle itself is suppressed
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rqs_q <= 1'b0;
			svc_prev_q <= 1'b0;
			poll_byte_q <= 8'h00;
		end else if (clk_en) begin
			svc_prev_q <= svc_sum;
			if (svc_sum && !svc_prev_q && !serial_poll) begin
				rqs_q <= 1'b1;
			end else if (serial_poll) begin
				rqs_q <= 1'b0;
			end else if (is_cls) begin
				rqs_q <= 1'b0;
			end
			if (serial_poll) begin
				poll_byte_q <= stb_now;
			end
		end
	end

	// ----------------------------------------
	// Query responses
	// ----------------------------------------
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			resp_valid_q <= 1'b0;
			resp_data_q <= 16'h0000;
		end else if (clk_en) begin
			resp_valid_q <= 1'b0;
			// A clear drops any answer that would be due
			if (dev_clear) begin
				resp_valid_q <= 1'b0;
			end else if (pending_opcq_q && state_q == ST_WAIT && !exec_busy) begin
				resp_valid_q <= 1'b1;
				resp_data_q <= 16'h0001;
			end else if (take) begin
				resp_valid_q <= 1'b1;
				case (cmd_code)
					`CMD_ESE_QRY: resp_data_q <= {8'h00, std_enable_q};
					`CMD_ESR_QRY: resp_data_q <= {8'h00, std_event_q};
					`CMD_PSC_QRY: resp_data_q <= {15'h0000, psc_q};
					`CMD_SRE_QRY: resp_data_q <= {8'h00, sre_q};
					`CMD_STB_QRY: resp_data_q <= {8'h00, stb_now};
					`CMD_QEN_QRY: resp_data_q <= ques_enable_q;
					`CMD_QEV_QRY: resp_data_q <= ques_event_q;
					default: resp_valid_q <= 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Device clear actions; status untouched
	// ----------------------------------------
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meas_abort_q <= 1'b0;
			trig_idle_q <= 1'b0;
			buf_flush_q <= 1'b0;
			dtr_q <= 1'b1;
		end else if (clk_en) begin
			// Action strobes last one cycle; data-terminal-ready is only raised
			meas_abort_q <= dev_clear;
			trig_idle_q <= dev_clear;
			buf_flush_q <= dev_clear;
			if (dev_clear) begin
				dtr_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Error queue, untouched by device clear
	// ----------------------------------------
	error_queue u_errq (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		// Full flag unused: a push into a full queue is dropped inside
		.push(err_push),
		.push_code(err_code),
		.pop(err_pop),
		.pop_code_q(err_pop_code),
		.empty(err_empty),
		.full()
	);

endmodule

// ==== status_consts.vh ====
// Constants for the meter_unit status reporting block.
// Assumes inclusion by the status block, error queue, checker, controller and bench.
`ifndef STATUS_CONSTS_VH
`define STATUS_CONSTS_VH

// ----------------------------------------
// Command codes on the command port
// ----------------------------------------
`define CMD_NONE 4'h0
`define CMD_CLS 4'h1
`define CMD_ESE_SET 4'h2
`define CMD_ESE_QRY 4'h3
`define CMD_ESR_QRY 4'h4
`define CMD_OPC 4'h5
`define CMD_OPC_QRY 4'h6
`define CMD_PSC_SET 4'h7
`define CMD_PSC_QRY 4'h8
`define CMD_SRE_SET 4'h9
`define CMD_SRE_QRY 4'hA
`define CMD_STB_QRY 4'hB
`define CMD_QEN_SET 4'hC
`define CMD_QEN_QRY 4'hD
`define CMD_QEV_QRY 4'hE
`define CMD_PRESET 4'hF

// ----------------------------------------
// Questionable register fields
// ----------------------------------------
`define QUES_VOLT_OVLD 0
`define QUES_CURR_OVLD 1
`define QUES_OHMS_OVLD 9
`define QUES_LIM_LO 11
`define QUES_LIM_HI 12
`define QUES_USED_MASK 16'h1A03

// ----------------------------------------
// Standard event fields
// ----------------------------------------
`define SEV_OPC 0
`define SEV_QUERY_ERR 2
`define SEV_DEV_ERR 3
`define SEV_EXEC_ERR 4
`define SEV_CMD_ERR 5
`define SEV_PWR_ON 7
`define SEV_USED_MASK 8'hBD

// ----------------------------------------
// Status byte fields
// ----------------------------------------
`define STB_QUES 3
`define STB_MAV 4
`define STB_ESB 5
`define STB_RQS 6

// ----------------------------------------
// Reset values and error queue sizes
// ----------------------------------------
`define QEN_RESET 16'h0000
`define MASK8_RESET 8'h00
`define ERRQ_DEPTH 20
`define ERRQ_PTR_W 5
`define ERRQ_CHARS 80
`define ERRQ_CODE_W 16
`define CTRL_C_CHAR 8'h03

`endif

// ==== error_queue.v ====
// First-in first-out store of error codes for the status block.
// Assumes one clock, asynchronous high reset and a freezing clock enable.
`timescale 1ns/100ps
`include "status_consts.vh"

module error_queue (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	input wire clk_en,
	// Push side
	input wire push,
	input wire [`ERRQ_CODE_W-1:0] push_code,
	// Pop side
	input wire pop,
	output reg [`ERRQ_CODE_W-1:0] pop_code_q,
	output wire empty,
	output wire full
);

	reg [`ERRQ_CODE_W-1:0] store_q [0:`ERRQ_DEPTH-1];
	reg [`ERRQ_PTR_W-1:0] rd_q;
	reg [`ERRQ_PTR_W-1:0] wr_q;
	reg [`ERRQ_PTR_W:0] count_q;
	wire do_push;
	wire do_pop;

	// Full queue drops the newest error; empty pop returns code zero
	assign empty = (count_q == 6'h00);
	assign full = (count_q == `ERRQ_DEPTH);
	assign do_push = push && !full;
	assign do_pop = pop && !empty;

	// Storage entries
	genvar i;
	generate
		for (i = 0; i < `ERRQ_DEPTH; i = i + 1) begin : g_ent
			always @(posedge core_clk or posedge reset) begin
				if (reset) begin
					store_q[i] <= 16'h0000;
				end else if (clk_en && do_push && wr_q == i) begin
					store_q[i] <= push_code;
				end
			end
		end
	endgenerate

	// Pointers and occupancy
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_q <= 5'h00;
			wr_q <= 5'h00;
			count_q <= 6'h00;
			pop_code_q <= 16'h0000;
		end else if (clk_en) begin
			if (do_push) begin
				wr_q <= (wr_q == `ERRQ_DEPTH - 1) ? 5'h00 : wr_q + 5'h01;
			end
			if (do_pop) begin
				pop_code_q <= store_q[rd_q];
				rd_q <= (rd_q == `ERRQ_DEPTH - 1) ? 5'h00 : rd_q + 5'h01;
			end else if (pop) begin
				pop_code_q <= 16'h0000;
			end
			if (do_push && !do_pop) begin
				count_q <= count_q + 6'h01;
			end else if (do_pop && !do_push) begin
				count_q <= count_q - 6'h01;
			end
		end
	end

endmodule

// ==== status_checker_asserts.sv ====
// Concurrent checks on the ports of the status block.
// Assumes one clock domain and a bind by name onto the block.
`timescale 1ns/100ps
`include "status_consts.vh"

module status_checker (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	input wire clk_en,
	// Command and response
	input wire cmd_valid,
	input wire [3:0] cmd_code,
	input wire cmd_ready,
	input wire resp_valid_q,
	input wire [15:0] resp_data_q,
	// Error queue and poll
	input wire err_push,
	input wire err_pop,
	input wire err_empty,
	input wire serial_poll,
	input wire srq,
	// Device clear
	input wire bus_dev_clear,
	input wire serial_rx_valid,
	input wire [7:0] serial_rx_char,
	input wire meas_abort_q,
	input wire trig_idle_q,
	input wire buf_flush_q,
	input wire dtr_q
);
	// Clear from either source, and a command taken at this edge
	wire dclr = bus_dev_clear | (serial_rx_valid && serial_rx_char == `CTRL_C_CHAR);
	wire tk = cmd_valid && cmd_ready && clk_en && !dclr;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_clear_actions: assert property (clk_en && dclr |=> meas_abort_q && trig_idle_q && buf_flush_q)
		else $error("clear actions missing");
	chk_dtr_after_clear: assert property (clk_en && dclr |=> dtr_q)
		else $error("dtr not true after clear");
	chk_ques_unused: assert property (tk && (cmd_code == `CMD_QEN_QRY || cmd_code == `CMD_QEV_QRY)
		|=> resp_valid_q && (resp_data_q & ~`QUES_USED_MASK) == 16'h0000)
		else $error("unused questionable bits set");
	chk_std_layout: assert property (tk && cmd_code == `CMD_ESR_QRY
		|=> resp_valid_q && resp_data_q[15:8] == 8'h00 && !resp_data_q[1] && !resp_data_q[6])
		else $error("standard event layout wrong");
	chk_opcq_wait: assert property (tk && cmd_code == `CMD_OPC_QRY |=> !resp_valid_q && !cmd_ready)
		else $error("early completion answer");
	chk_opc_wait: assert property (tk && cmd_code == `CMD_OPC |=> !cmd_ready)
		else $error("completion wait not opened");
	chk_stb_keeps_rqs: assert property (tk && cmd_code == `CMD_STB_QRY && srq && !serial_poll |=> srq)
		else $error("status query cleared request");
	chk_poll_clears_rqs: assert property (serial_poll && clk_en |=> !srq)
		else $error("poll left request set");
	chk_push_not_empty: assert property (err_push && !err_pop && clk_en |=> !err_empty)
		else $error("queue empty after push");
endmodule

bind instrument_status_reporting status_checker u_chk (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready), .resp_valid_q(resp_valid_q),
	.resp_data_q(resp_data_q), .err_push(err_push), .err_pop(err_pop), .err_empty(err_empty),
	.serial_poll(serial_poll), .srq(srq), .bus_dev_clear(bus_dev_clear), .serial_rx_valid(serial_rx_valid),
	.serial_rx_char(serial_rx_char), .meas_abort_q(meas_abort_q), .trig_idle_q(trig_idle_q),
	.buf_flush_q(buf_flush_q), .dtr_q(dtr_q));

// ==== bus_controller.sv ====
// Remote controller model: sends commands and serial characters.
// Assumes the block samples its inputs on rising core_clk edges.
`timescale 1ns/100ps
`include "status_consts.vh"

module bus_controller (
	// Clock and handshake
	input wire core_clk,
	input wire cmd_ready,
	// Command port
	output reg cmd_valid,
	output reg [3:0] cmd_code,
	output reg [15:0] cmd_data,
	// Serial receive
	output reg serial_rx_valid,
	output reg [7:0] serial_rx_char
);
	// Idle lines at time zero
	initial begin
		{cmd_valid, cmd_code, cmd_data, serial_rx_valid, serial_rx_char} = '0;
	end
	// Hold a command until ready is seen, then scramble the released lines
	task send(input [3:0] c, input [15:0] d);
		begin
			@(posedge core_clk);
			cmd_valid <= 1'b1;
			cmd_code <= c;
			cmd_data <= d;
			@(negedge core_clk);
			while (cmd_ready !== 1'b1) @(negedge core_clk);
			@(posedge core_clk);
			cmd_valid <= 1'b0;
			cmd_code <= ~c;
			cmd_data <= ~d;
		end
	endtask
	// One break character on the serial line
	task ctrl_c;
		begin
			@(posedge core_clk);
			serial_rx_valid <= 1'b1;
			serial_rx_char <= `CTRL_C_CHAR;
			@(posedge core_clk);
			serial_rx_valid <= 1'b0;
			serial_rx_char <= 8'hFC;
		end
	endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the status block and controller model.
// Assumes the design files and status_consts.vh are compiled first.
`timescale 1ns/100ps
`include "status_consts.vh"

module testbench;
	logic core_clk, reset, clk_en, power_up, psc_nv_in, exec_busy, err_push, err_pop, serial_poll, bus_dev_clear;
	logic cmd_valid, cmd_ready, resp_valid_q, err_empty, srq, serial_rx_valid, meas_abort_q, trig_idle_q;
	logic buf_flush_q, dtr_q, psc_nv_write_q, psc_nv_value_q;
	logic [3:0] cmd_code;
	logic [9:0] ev;
	logic [7:0] poll_byte_q, serial_rx_char;
	logic [15:0] cmd_data, resp_data_q, err_code, err_pop_code;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	// ----------------------------------------
	// Design and controller
	// ----------------------------------------
	instrument_status_reporting u_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .power_up(power_up),
		.psc_nv_in(psc_nv_in), .psc_nv_write_q(psc_nv_write_q), .psc_nv_value_q(psc_nv_value_q),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data), .exec_busy(exec_busy),
		.cmd_ready(cmd_ready), .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q), .ovld_volt(ev[0]),
		.ovld_curr(ev[1]), .ovld_ohms(ev[2]), .lim_low_fail(ev[3]), .lim_high_fail(ev[4]), .std_query_err(ev[5]),
		.std_dev_err(ev[6]), .std_exec_err(ev[7]), .std_cmd_err(ev[8]), .msg_avail(ev[9]),
		.err_push(err_push), .err_code(err_code), .err_pop(err_pop), .err_pop_code(err_pop_code),
		.err_empty(err_empty), .serial_poll(serial_poll), .poll_byte_q(poll_byte_q), .srq(srq),
		.bus_dev_clear(bus_dev_clear), .serial_rx_valid(serial_rx_valid), .serial_rx_char(serial_rx_char),
		.meas_abort_q(meas_abort_q), .trig_idle_q(trig_idle_q), .buf_flush_q(buf_flush_q), .dtr_q(dtr_q));
	bus_controller u_ctrl (.core_clk(core_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_data(cmd_data), .serial_rx_valid(serial_rx_valid), .serial_rx_char(serial_rx_char));
	// Clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			wrap_up;
		end
	end
	task wrap_up;
		begin
			$display("errors %0d checks %0d", error_cnt, checks_done);
			if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	// Compare and count
	task chk(input [15:0] exp, input [15:0] got, input string nm);
		begin
			checks_done++;
			if (got !== exp) begin
				$display("unexpected %s expected %h seen %h", nm, exp, got);
				error_cnt++;
			end
		end
	endtask
	// Query and judge the one-cycle answer
	task q(input [3:0] c, input [15:0] exp, input string nm);
		begin
			u_ctrl.send(c, 16'h0000);
			#1;
			chk(16'h0001, resp_valid_q, "resp_valid_q");
			chk(exp, resp_data_q, nm);
		end
	endtask
	task pulse_ev(input [9:0] m);
		begin
			@(posedge core_clk) ev <= m;
			@(posedge core_clk) ev <= 10'h000;
		end
	endtask
	task push(input [15:0] c);
		begin
			@(posedge core_clk) err_push <= 1'b1;
			err_code <= c;
			@(posedge core_clk) err_push <= 1'b0;
		end
	endtask
	task pop(input [15:0] exp);
		begin
			@(posedge core_clk) err_pop <= 1'b1;
			@(posedge core_clk) err_pop <= 1'b0;
			@(posedge core_clk);
			#1 chk(exp, err_pop_code, "err_pop_code");
		end
	endtask
	task pwr(input v);
		begin
			@(posedge core_clk) power_up <= 1'b1;
			psc_nv_in <= v;
			@(posedge core_clk) power_up <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_ques;
		logic [15:0] w [5];
		begin
			w = '{16'h0001, 16'h0002, 16'h0200, 16'h0800, 16'h1000};
			for (int i = 0; i < 5; i++) begin
				pulse_ev(10'(10'h001 << i));
				q(`CMD_QEV_QRY, w[i], "ques_event");
			end
			q(`CMD_QEV_QRY, 16'h0000, "ques_after_read");
			@(posedge core_clk) clk_en <= 1'b0;
			pulse_ev(10'h001);
			@(posedge core_clk) clk_en <= 1'b1;
			q(`CMD_QEV_QRY, 16'h0000, "ques_frozen");
		end
	endtask
	task t_qen;
		begin
			u_ctrl.send(`CMD_QEN_SET, 16'hFFFF);
			q(`CMD_QEN_QRY, 16'h1A03, "ques_enable");
			pulse_ev(10'h004);
			q(`CMD_STB_QRY, 16'h0008, "stb_ques_sum");
			u_ctrl.send(`CMD_PRESET, 16'h0000);
			q(`CMD_QEN_QRY, 16'h0000, "qen_preset");
			u_ctrl.send(`CMD_QEN_SET, 16'hFFFF);
			u_ctrl.send(`CMD_QEN_SET, 16'h0000);
			q(`CMD_QEN_QRY, 16'h0000, "ques_enable_zero");
			q(`CMD_STB_QRY, 16'h0000, "stb_masked");
			q(`CMD_QEV_QRY, 16'h0200, "ques_event_kept");
		end
	endtask
	task t_cls;
		begin
			@(posedge core_clk) ev <= 10'h200;
			q(`CMD_STB_QRY, 16'h0010, "stb_mav");
			u_ctrl.send(`CMD_ESE_SET, 16'h00BD);
			pulse_ev(10'h1F0);
			q(`CMD_STB_QRY, 16'h0020, "stb_esb_err");
			q(`CMD_ESR_QRY, 16'h003C, "esr_errors");
			pulse_ev(10'h1E0);
			u_ctrl.send(`CMD_CLS, 16'h0000);
			q(`CMD_ESR_QRY, 16'h0000, "esr_after_cls");
			q(`CMD_QEV_QRY, 16'h0000, "ques_after_cls");
			q(`CMD_ESE_QRY, 16'h00BD, "ese_kept");
		end
	endtask
	task t_opc;
		begin
			@(posedge core_clk) exec_busy <= 1'b1;
			u_ctrl.send(`CMD_OPC, 16'h0000);
			repeat (3) @(posedge core_clk);
			#1 chk(16'h0000, cmd_ready, "cmd_ready");
			@(posedge core_clk) exec_busy <= 1'b0;
			repeat (3) @(posedge core_clk);
			q(`CMD_STB_QRY, 16'h0020, "stb_esb");
			q(`CMD_ESR_QRY, 16'h0001, "esr_opc");
			@(posedge core_clk) exec_busy <= 1'b1;
			u_ctrl.send(`CMD_OPC_QRY, 16'h0000);
			for (int k = 0; k < 4; k++) begin
				@(posedge core_clk);
				#1 chk(16'h0000, resp_valid_q, "early_resp");
			end
			@(posedge core_clk) exec_busy <= 1'b0;
			for (int k = 0; k < 6 && resp_valid_q !== 1'b1; k++) begin
				@(posedge core_clk);
				#1;
			end
			chk(16'h0001, resp_valid_q, "opc_query_valid");
			chk(16'h0001, resp_data_q, "opc_query");
		end
	endtask
	task t_poll;
		begin
			u_ctrl.send(`CMD_SRE_SET, 16'h0008);
			u_ctrl.send(`CMD_QEN_SET, 16'h0001);
			pulse_ev(10'h001);
			repeat (3) @(posedge core_clk);
			#1 chk(16'h0001, srq, "srq_set");
			q(`CMD_STB_QRY, 16'h0048, "stb_rqs");
			chk(16'h0001, srq, "srq_kept");
			@(posedge core_clk) serial_poll <= 1'b1;
			@(posedge core_clk) serial_poll <= 1'b0;
			#1 chk(16'h0048, poll_byte_q, "poll_byte");
			chk(16'h0000, srq, "srq_polled");
			q(`CMD_STB_QRY, 16'h0008, "stb_after_poll");
			u_ctrl.send(`CMD_CLS, 16'h0000);
			q(`CMD_STB_QRY, 16'h0000, "stb_after_cls");
		end
	endtask
	task t_dclr;
		begin
			push(16'h00A1);
			push(16'h00B2);
			@(posedge core_clk) bus_dev_clear <= 1'b1;
			@(posedge core_clk) bus_dev_clear <= 1'b0;
			#1 chk(16'h0007, {meas_abort_q, trig_idle_q, buf_flush_q}, "clear_actions");
			chk(16'h0001, dtr_q, "dtr_q");
			u_ctrl.ctrl_c;
			#1 chk(16'h0007, {meas_abort_q, trig_idle_q, buf_flush_q}, "break_actions");
			q(`CMD_QEN_QRY, 16'h0001, "qen_after_clear");
			pop(16'h00A1);
			pop(16'h00B2);
		end
	endtask
	task t_err;
		begin
			for (int i = 0; i < 21; i++) push(16'(16'h0100 + i));
			for (int i = 0; i < 20; i++) pop(16'(16'h0100 + i));
			chk(16'h0001, err_empty, "err_empty");
			pop(16'h0000);
		end
	endtask
	task t_psc;
		begin
			u_ctrl.send(`CMD_PSC_SET, 16'h0001);
			#1 chk(16'h0001, psc_nv_write_q, "psc_nv_write_q");
			chk(16'h0001, psc_nv_value_q, "psc_nv_value_q");
			q(`CMD_PSC_QRY, 16'h0001, "psc");
			u_ctrl.send(`CMD_ESE_SET, 16'h0020);
			pwr(1'b0);
			q(`CMD_ESE_QRY, 16'h0020, "ese_psc0");
			q(`CMD_SRE_QRY, 16'h0008, "sre_psc0");
			q(`CMD_QEN_QRY, 16'h0000, "qen_power_up");
			q(`CMD_ESR_QRY, 16'h0080, "esr_power_on");
			pwr(1'b1);
			q(`CMD_ESE_QRY, 16'h0000, "ese_psc1");
			q(`CMD_SRE_QRY, 16'h0000, "sre_psc1");
		end
	endtask
	// Main sequence
	initial begin
		{power_up, psc_nv_in, exec_busy, err_push, err_pop, serial_poll, bus_dev_clear} = '0;
		ev = 10'h000;
		err_code = 16'h0000;
		clk_en = 1'b1;
		reset = 1'b1;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		q(`CMD_QEN_QRY, `QEN_RESET, "qen_reset");
		t_ques;
		t_qen;
		t_cls;
		t_opc;
		t_poll;
		t_dclr;
		t_err;
		t_psc;
		wrap_up;
	end
endmodule
